/* File: pkg/flash_cmd_pkg.sv */
// opcodes, field positions and reset values for the status-write and reset
// command handler; shared by the frame receiver and the command core.
package flash_cmd_pkg;
	localparam logic [7:0] OP_STATUS_WRITE_1 = 8'h01;
	localparam logic [7:0] OP_STATUS_WRITE_2 = 8'h31;
	localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
	localparam logic [7:0] RESET_CONFIRM = 8'hD0;
	localparam int LOCK_POS = 7;
	localparam int GLOBAL_MSB = 5;
	localparam int GLOBAL_LSB = 2;
	localparam int RESET_EN_POS = 4;
	localparam int LOCKDOWN_EN_POS = 3;
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 3'h1;
	localparam logic STATUS_RESET_VAL = 1'b0;
	localparam int SYNC_W = 4;
	// select and write-protect idle high, serial clock and data low
	localparam logic [SYNC_W-1:0] SYNC_INIT = 4'h9;
	typedef enum logic [5:0] {
		ST_OPCODE = 6'h01,
		ST_WRITE_1 = 6'h02,
		ST_WRITE_2 = 6'h04,
		ST_RST_OP = 6'h08,
		ST_RST_CONF = 6'h10,
		ST_IGNORE = 6'h20
	} cmd_state_type;
endpackage : flash_cmd_pkg

/* File: core/pin_sync.sv */
// two-flop synchroniser for a bundle of pin levels.
// assumes each bit is an independent slow level; no bus coherency is kept.
`timescale 1ns/1ps
module pin_sync
	import flash_cmd_pkg::*;
#(
	parameter int WIDTH = SYNC_W,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule : pin_sync

/* File: core/spi_frame_rx.sv */
// spi mode 0/3 byte receiver working from synchronised pin levels.
// assumes the serial clock is well below a quarter of the system clock.
`timescale 1ns/1ps
module spi_frame_rx
	import flash_cmd_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// synchronised pins
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_mosi,
	// received bytes and frame end
	output logic o_byte_stb,
	output logic [7:0] o_byte,
	output logic o_frame_end,
	output logic o_frame_aligned
);
	logic sclk_prev_reg, sclk_prev_next;
	logic cs_prev_reg, cs_prev_next;
	logic [7:0] shift_reg, shift_next;
	logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
	logic stb_reg, stb_next;
	logic [7:0] byte_reg, byte_next;
	logic end_reg, end_next;
	logic aligned_reg, aligned_next;
	logic [7:0] shifted;

	always_comb begin
		sclk_prev_next = i_sclk;
		cs_prev_next = i_cs_n;
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		stb_next = 1'b0;
		byte_next = byte_reg;
		end_next = 1'b0;
		aligned_next = aligned_reg;
		shifted = {shift_reg[6:0], i_mosi};
		// every select-low period is one frame, counted bit by bit
		if (i_cs_n) begin
			cnt_next = BIT_CNT_ZERO;
			if (!cs_prev_reg) begin
				end_next = 1'b1;
				aligned_next = (cnt_reg == BIT_CNT_ZERO);
			end
		end else if (i_sclk && !sclk_prev_reg) begin
			shift_next = shifted;
			cnt_next = cnt_reg + BIT_CNT_ONE;
			if (cnt_reg == ~BIT_CNT_ZERO) begin
				stb_next = 1'b1;
				byte_next = shifted;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sclk_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
			shift_reg <= 8'h00;
			cnt_reg <= BIT_CNT_ZERO;
			stb_reg <= 1'b0;
			byte_reg <= 8'h00;
			end_reg <= 1'b0;
			aligned_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_prev_next;
			cs_prev_reg <= cs_prev_next;
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
			stb_reg <= stb_next;
			byte_reg <= byte_next;
			end_reg <= end_next;
			aligned_reg <= aligned_next;
		end
	end

	assign o_byte_stb = stb_reg;
	assign o_byte = byte_reg;
	assign o_frame_end = end_reg;
	assign o_frame_aligned = aligned_reg;
endmodule : spi_frame_rx

/* File: core/flash_status_cmd.sv */
// status-write and software reset command handler of the serial flash.
// assumes write-enable, freeze and suspend events come as one-cycle pulses
// from the other command logic on I_SYS_CLK; spi pins are asynchronous.
`timescale 1ns/1ps
module flash_status_cmd
	import flash_cmd_pkg::*;
(
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_ARST_N,
	// spi pins
	input wire logic I_CS_N,
	input wire logic I_SCLK,
	input wire logic I_MOSI,
	input wire logic I_WP_N,
	// events from the other command logic
	input wire logic I_LATCH_SET,
	input wire logic I_FREEZE_LOCKDOWN,
	input wire logic I_PROG_SUSPEND_SET,
	input wire logic I_ERASE_SUSPEND_SET,
	input wire logic I_RESUME,
	// status bits
	output logic O_PROTECTION_LOCK_BIT,
	output logic O_WRITE_ENABLE_LATCH,
	output logic O_RESET_COMMAND_ENABLE,
	output logic O_LOCKDOWN_COMMAND_ENABLE,
	output logic O_PROGRAM_SUSPEND_FLAG,
	output logic O_ERASE_SUSPEND_FLAG,
	// actions
	output logic O_SECTOR_PROT_ALLOW,
	output logic O_GLOBAL_PROT_STB,
	output logic [GLOBAL_MSB-GLOBAL_LSB:0] O_GLOBAL_PROT_CODE,
	output logic O_ARRAY_ABORT
);
	logic [SYNC_W-1:0] pins_s;
	logic cs_n_s, sclk_s, mosi_s, wp_n_s;
	logic byte_stb, frame_end, frame_aligned;
	logic [7:0] rx_byte;

	cmd_state_type state_reg, state_next;
	logic got_data_reg, got_data_next;
	logic [7:0] data_reg, data_next;
	logic lock_reg, lock_next;
	logic latch_reg, latch_next;
	logic rst_en_reg, rst_en_next;
	logic lkd_en_reg, lkd_en_next;
	logic frozen_reg, frozen_next;
	logic prog_susp_reg, prog_susp_next;
	logic erase_susp_reg, erase_susp_next;
	logic gstb_reg, gstb_next;
	logic [GLOBAL_MSB-GLOBAL_LSB:0] gcode_reg, gcode_next;
	logic abort_reg, abort_next;
	logic complete;

	// idle-high select and write-protect so reset does not look like a frame
	pin_sync #(
		.WIDTH(SYNC_W),
		.INIT(SYNC_INIT)
	) u_sync (
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.i_async({I_CS_N, I_SCLK, I_MOSI, I_WP_N}),
		.o_sync(pins_s)
	);
	assign {cs_n_s, sclk_s, mosi_s, wp_n_s} = pins_s;

	spi_frame_rx u_rx (
		.i_clk(I_SYS_CLK),
		.i_arst_n(I_ARST_N),
		.i_cs_n(cs_n_s),
		.i_sclk(sclk_s),
		.i_mosi(mosi_s),
		.o_byte_stb(byte_stb),
		.o_byte(rx_byte),
		.o_frame_end(frame_end),
		.o_frame_aligned(frame_aligned)
	);

	assign complete = got_data_reg && frame_aligned;

	// frame decode
	always_comb begin
		state_next = state_reg;
		got_data_next = got_data_reg;
		data_next = data_reg;
		if (frame_end) begin
			state_next = ST_OPCODE;
			got_data_next = 1'b0;
		end else if (byte_stb) begin
			case (state_reg)
				ST_OPCODE: begin
					got_data_next = 1'b0;
					if (rx_byte == OP_STATUS_WRITE_1 && latch_reg) begin
						state_next = ST_WRITE_1;
					end else if (rx_byte == OP_STATUS_WRITE_2 && latch_reg) begin
						state_next = ST_WRITE_2;
					end else if (rx_byte == OP_SOFT_RESET) begin
						state_next = ST_RST_OP;
					end else begin
						state_next = ST_IGNORE;
					end
				end
				ST_WRITE_1, ST_WRITE_2: begin
					// only the first data byte counts
					if (!got_data_reg) begin
						data_next = rx_byte;
						got_data_next = 1'b1;
					end
				end
				ST_RST_OP: begin
					state_next = (rx_byte == RESET_CONFIRM) ? ST_RST_CONF : ST_IGNORE;
				end
				ST_RST_CONF: begin
					got_data_next = 1'b1;
				end
				ST_IGNORE: begin
					state_next = ST_IGNORE;
				end
				default: begin
					state_next = ST_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_reg <= ST_OPCODE;
			got_data_reg <= 1'b0;
			data_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			got_data_reg <= got_data_next;
			data_reg <= data_next;
		end
	end

	// status bits and actions taken at frame end
	always_comb begin
		lock_next = lock_reg;
		latch_next = latch_reg;
		rst_en_next = rst_en_reg;
		lkd_en_next = lkd_en_reg;
		frozen_next = frozen_reg | I_FREEZE_LOCKDOWN;
		prog_susp_next = prog_susp_reg & ~I_RESUME;
		erase_susp_next = erase_susp_reg & ~I_RESUME;
		gstb_next = 1'b0;
		gcode_next = gcode_reg;
		abort_next = 1'b0;
		if (frame_end) begin
			case (state_reg)
				ST_WRITE_1: begin
					latch_next = 1'b0;
					// with wp asserted, a write of 0 drops the lock, code and strobe update; the latch still clears
					if (complete && (wp_n_s || data_reg[LOCK_POS])) begin
						lock_next = data_reg[LOCK_POS];
						gcode_next = data_reg[GLOBAL_MSB:GLOBAL_LSB];
						gstb_next = ~lock_reg;
					end
				end
				ST_WRITE_2: begin
					latch_next = 1'b0;
					if (complete) begin
						rst_en_next = data_reg[RESET_EN_POS];
						if (!frozen_reg) begin
							lkd_en_next = data_reg[LOCKDOWN_EN_POS];
						end
					end
				end
				ST_RST_CONF: begin
					if (frame_aligned && rst_en_reg) begin
						abort_next = 1'b1;
						latch_next = 1'b0;
						prog_susp_next = 1'b0;
						erase_susp_next = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// a new event in the clearing cycle still lands
		if (I_LATCH_SET) begin
			latch_next = 1'b1;
		end
		if (I_PROG_SUSPEND_SET) begin
			prog_susp_next = 1'b1;
		end
		if (I_ERASE_SUSPEND_SET) begin
			erase_susp_next = 1'b1;
		end
		if (frozen_next) begin
			lkd_en_next = 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			lock_reg <= STATUS_RESET_VAL;
			latch_reg <= STATUS_RESET_VAL;
			rst_en_reg <= STATUS_RESET_VAL;
			lkd_en_reg <= STATUS_RESET_VAL;
			frozen_reg <= 1'b0;
			prog_susp_reg <= 1'b0;
			erase_susp_reg <= 1'b0;
			gstb_reg <= 1'b0;
			gcode_reg <= 4'h0;
			abort_reg <= 1'b0;
		end else begin
			lock_reg <= lock_next;
			latch_reg <= latch_next;
			rst_en_reg <= rst_en_next;
			lkd_en_reg <= lkd_en_next;
			frozen_reg <= frozen_next;
			prog_susp_reg <= prog_susp_next;
			erase_susp_reg <= erase_susp_next;
			gstb_reg <= gstb_next;
			gcode_reg <= gcode_next;
			abort_reg <= abort_next;
		end
	end

	assign O_PROTECTION_LOCK_BIT = lock_reg;
	assign O_WRITE_ENABLE_LATCH = latch_reg;
	assign O_RESET_COMMAND_ENABLE = rst_en_reg;
	assign O_LOCKDOWN_COMMAND_ENABLE = lkd_en_reg;
	assign O_PROGRAM_SUSPEND_FLAG = prog_susp_reg;
	assign O_ERASE_SUSPEND_FLAG = erase_susp_reg;
	assign O_SECTOR_PROT_ALLOW = ~lock_reg;
	assign O_GLOBAL_PROT_STB = gstb_reg;
	assign O_GLOBAL_PROT_CODE = gcode_reg;
	assign O_ARRAY_ABORT = abort_reg;

	// checks
	sequence s_w1_end;
		frame_end && state_reg == ST_WRITE_1;
	endsequence
	sequence s_w2_end;
		frame_end && state_reg == ST_WRITE_2;
	endsequence
	sequence s_rst_end;
		frame_end && state_reg == ST_RST_CONF && frame_aligned;
	endsequence

	property p_write_gate;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		state_reg == ST_OPCODE && byte_stb && !frame_end && !latch_reg
		|=> state_reg != ST_WRITE_1 && state_reg != ST_WRITE_2;
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("write entered without latch");

	property p_w1_clears_latch;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		s_w1_end ##0 !I_LATCH_SET |=> !latch_reg;
	endproperty
	a_w1_clears_latch: assert property (p_w1_clears_latch) else $error("latch kept");

	property p_w1_abort_keeps_lock;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		s_w1_end ##0 !complete |=> $stable(lock_reg) && !gstb_reg;
	endproperty
	a_w1_abort_keeps_lock: assert property (p_w1_abort_keeps_lock) else $error("abort changed lock");

	property p_wp_holds_lock;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		s_w1_end ##0 (!wp_n_s && lock_reg) |=> lock_reg;
	endproperty
	a_wp_holds_lock: assert property (p_wp_holds_lock) else $error("lock cleared under wp");

	property p_global_unlocked;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		gstb_reg |-> !$past(lock_reg) && $past(complete);
	endproperty
	a_global_unlocked: assert property (p_global_unlocked) else $error("global while locked");

	property p_w2_update;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		s_w2_end ##0 complete |=> rst_en_reg == $past(data_reg[RESET_EN_POS]);
	endproperty
	a_w2_update: assert property (p_w2_update) else $error("reset enable not written");

	property p_w2_abort;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		s_w2_end ##0 !complete |=> $stable(rst_en_reg) && ($stable(lkd_en_reg) || frozen_reg);
	endproperty
	a_w2_abort: assert property (p_w2_abort) else $error("abort changed reset enable");

	property p_reset_needs_enable;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		s_rst_end |=> O_ARRAY_ABORT == $past(rst_en_reg);
	endproperty
	a_reset_needs_enable: assert property (p_reset_needs_enable) else $error("reset gate wrong");

	property p_reset_effect;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		abort_reg |-> $stable(lock_reg) && $stable(rst_en_reg)
			&& !prog_susp_reg == !$past(I_PROG_SUSPEND_SET)
			&& !erase_susp_reg == !$past(I_ERASE_SUSPEND_SET)
			&& !latch_reg == !$past(I_LATCH_SET)
			##1 !abort_reg;
	endproperty
	a_reset_effect: assert property (p_reset_effect) else $error("reset side effects wrong");

	property p_frozen_lockdown;
		@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
		frozen_reg |-> !lkd_en_reg;
	endproperty
	a_frozen_lockdown: assert property (p_frozen_lockdown) else $error("lockdown enable after freeze");
endmodule : flash_status_cmd

/* File: sim/spi_host_model.sv */
// spi host model: drives select, serial clock and data in mode 0, msb first.
// assumes the caller is the only user; one frame at a time.
`timescale 1ns/1ps
module spi_host_model (
	// clock
	input wire logic i_clk,
	// spi pins
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_mosi
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	// frame bits come from the top of the vector; counts not a multiple of 8 give unaligned ends
	task automatic frame(input logic [23:0] bits, input int n_bits);
		step(1);
		o_cs_n = 1'b0;
		for (int k = 0; k < n_bits; k++) begin
			step(4);
			// data changes with the clock low; the rising edge samples it
			o_sclk = 1'b0;
			o_mosi = bits[23-k];
			step(4);
			o_sclk = 1'b1;
		end
		step(4);
		o_sclk = 1'b0;
		step(4);
		o_cs_n = 1'b1;
		// released data line must not keep its last value
		o_mosi = ~o_mosi;
		step(8);
	endtask : frame
endmodule : spi_host_model

/* File: sim/spi_flash_status_write_and_reset_bench.sv */
// self-checking bench for the status-write and reset command handler.
// assumes the spi host model drives the pins; events are one-cycle pulses.
`timescale 1ns/1ps
module spi_flash_status_write_and_reset_bench;
	import flash_cmd_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wp_n = 1'b1;
	logic [4:0] ev = 5'h00;
	logic cs_n, sclk, mosi;
	logic lock, latch, rsten, lkd, psusp, esusp, allow, stb, abort;
	logic [GLOBAL_MSB-GLOBAL_LSB:0] code;
	int n_errors = 0;
	int n_compared = 0;
	int n_stb = 0;
	int n_abort = 0;

	initial begin
		forever #10 clk = ~clk;
	end

	spi_host_model i_spi_host_model (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

	flash_status_cmd i_flash_status_cmd (
		.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_CS_N(cs_n), .I_SCLK(sclk), .I_MOSI(mosi),
		.I_WP_N(wp_n), .I_LATCH_SET(ev[0]), .I_FREEZE_LOCKDOWN(ev[1]),
		.I_PROG_SUSPEND_SET(ev[2]), .I_ERASE_SUSPEND_SET(ev[3]), .I_RESUME(ev[4]),
		.O_PROTECTION_LOCK_BIT(lock), .O_WRITE_ENABLE_LATCH(latch),
		.O_RESET_COMMAND_ENABLE(rsten), .O_LOCKDOWN_COMMAND_ENABLE(lkd),
		.O_PROGRAM_SUSPEND_FLAG(psusp), .O_ERASE_SUSPEND_FLAG(esusp),
		.O_SECTOR_PROT_ALLOW(allow), .O_GLOBAL_PROT_STB(stb),
		.O_GLOBAL_PROT_CODE(code), .O_ARRAY_ABORT(abort)
	);

	// one-cycle pulses are counted on every rising edge so none is missed
	always @(posedge clk) begin
		if (stb === 1'b1) n_stb++;
		if (abort === 1'b1) n_abort++;
	end

	task automatic chk(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : chk

	task automatic st(input logic [3:0] e);
		chk(lock === e[3], "lock bit");
		chk(latch === e[2], "write latch");
		chk(rsten === e[1], "reset enable");
		chk(lkd === e[0], "lockdown enable");
	endtask : st

	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		#1 ev = v;
		@(posedge clk);
		#1 ev = 5'h00;
	endtask : pulse

	task automatic done(input string name);
		$display("test %s done, %0d errors so far", name, n_errors);
	endtask : done

	task automatic results;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	initial begin
		#1000000;
		n_errors++;
		$display("unexpected at %0t: run hung", $time);
		results();
	end

	initial begin
		repeat (4) @(posedge clk);
		#1 arst_n = 1'b1;
		st(4'h0);
		chk(psusp === 1'b0 && esusp === 1'b0 && allow === 1'b1, "power-up flags");
		repeat (4) @(posedge clk);
		done("power-up");
		i_spi_host_model.frame(24'h018000, 16);
		st(4'h0);
		pulse(5'h01);
		chk(latch === 1'b1, "latch set");
		i_spi_host_model.frame(24'h01BC55, 24);
		st(4'h8);
		chk(n_stb == 1 && code === 4'hF, "global request");
		chk(allow === 1'b0, "protect refused while locked");
		done("write one");
		wp_n = 1'b0;
		pulse(5'h01);
		i_spi_host_model.frame(24'h010000, 16);
		st(4'h8);
		wp_n = 1'b1;
		pulse(5'h01);
		i_spi_host_model.frame(24'h010000, 16);
		st(4'h0);
		chk(n_stb == 1, "no global with prior lock");
		done("write protect");
		pulse(5'h01);
		i_spi_host_model.frame(24'h018000, 12);
		st(4'h0);
		pulse(5'h01);
		i_spi_host_model.frame(24'h018000, 20);
		st(4'h0);
		pulse(5'h01);
		i_spi_host_model.frame(24'h015C00, 16);
		chk(n_stb == 2 && code === 4'h7, "code bits");
		done("write one abort");
		pulse(5'h01);
		i_spi_host_model.frame(24'h31FF00, 16);
		st(4'h3);
		pulse(5'h01);
		i_spi_host_model.frame(24'h310000, 8);
		st(4'h3);
		pulse(5'h01);
		i_spi_host_model.frame(24'h310000, 13);
		st(4'h3);
		pulse(5'h02);
		chk(lkd === 1'b0, "freeze clears lockdown");
		pulse(5'h01);
		i_spi_host_model.frame(24'h31FF00, 16);
		st(4'h2);
		done("write two");
		pulse(5'h0C);
		pulse(5'h01);
		chk(psusp === 1'b1 && esusp === 1'b1, "suspend set");
		i_spi_host_model.frame(24'hF0D0AA, 24);
		chk(n_abort == 1, "reset aborts");
		st(4'h2);
		chk(psusp === 1'b0 && esusp === 1'b0, "suspend cleared");
		i_spi_host_model.frame(24'hF0D000, 16);
		chk(n_abort == 2, "reset without latch");
		i_spi_host_model.frame(24'hF0D100, 16);
		i_spi_host_model.frame(24'hF0D000, 20);
		i_spi_host_model.frame(24'hF00000, 8);
		chk(n_abort == 2, "incomplete resets refused");
		pulse(5'h01);
		i_spi_host_model.frame(24'h310000, 16);
		i_spi_host_model.frame(24'hF0D000, 16);
		chk(rsten === 1'b0 && n_abort == 2, "reset disabled");
		pulse(5'h0C);
		i_spi_host_model.frame(24'hF0D000, 16);
		chk(psusp === 1'b1 && esusp === 1'b1, "refused reset keeps suspend");
		pulse(5'h10);
		chk(psusp === 1'b0 && esusp === 1'b0, "resume clears suspend");
		done("reset");
		results();
	end
endmodule : spi_flash_status_write_and_reset_bench
